// File: design/pfe_equalizer_filter.sv
// Programmable FIR equalizer: register file, coefficient banks and mode routing
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module pfe_equalizer_filter
	import pfe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Sample stream from the converter core
	input wire pfe_iq_t din,
	// Sample stream to the downconverters
	output pfe_iq_t dout
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [2:0] mode_r;
	logic [2:0] gain_x;
	logic [2:0] gain_y;
	logic pend;
	pfe_bank_t xw;
	pfe_bank_t yw;
	pfe_bank_t xa;
	pfe_bank_t ya;
	logic in_x;
	logic in_y;
	logic [6:0] idx;
	logic coef_wr;
	logic xfer;
	logic signed [SW-1:0] yi_in;
	logic signed [SW-1:0] yq_in;
	logic signed [SW-1:0] tail_xi;
	logic signed [SW-1:0] tail_xq;
	logic signed [AW-1:0] fxi;
	logic signed [AW-1:0] fxq;
	logic signed [AW-1:0] fyi;
	logic signed [AW-1:0] fyq;
	logic signed [AW-1:0] gxi;
	logic signed [AW-1:0] gxq;
	logic signed [AW-1:0] gyi;
	logic signed [AW-1:0] gyq;
	pfe_iq_t next_dout;
	logic [7:0] next_rdata;

	// Drop the fraction bits and clamp to the sample width
	function automatic logic signed [SW-1:0] sat_out(input logic signed [AW-1:0] v);
		logic signed [AW-1:0] s;
		s = v >>> FRAC;
		if (s > AW'(2 ** (SW - 1) - 1))
			sat_out = SW'(2 ** (SW - 1) - 1);
		else if (s < -AW'(2 ** (SW - 1)))
			sat_out = SW'(-(2 ** (SW - 1)));
		else
			sat_out = s[SW-1:0];
	endfunction

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign in_x = (addr[15:7] == ADDR_XBASE[15:7]);
	assign in_y = (addr[15:7] == ADDR_YBASE[15:7]);
	assign idx = addr[6:0];
	assign coef_wr = wr && (in_x || in_y);
	assign xfer = wr && (addr == ADDR_XFER) && wdata[XFER_BIT];

	// ------------------------------------------------------------
	// Mode and gain registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			mode_r <= RST_MODE;
		else if (wr && addr == ADDR_MODE)
			mode_r <= wdata[2:0];
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			gain_x <= RST_GAIN;
			gain_y <= RST_GAIN;
		end
		else if (wr && addr == ADDR_GAIN)
		begin
			gain_x <= wdata[GX_LSB+:3];
			gain_y <= wdata[GY_LSB+:3];
		end
	end

	// ------------------------------------------------------------
	// Coefficient write banks
	// ------------------------------------------------------------
	// X bank storage
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			xw <= {BANK_BYTES{RST_BYTE}};
		else if (wr && in_x)
			xw[idx] <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			yw <= {BANK_BYTES{RST_BYTE}};
		else if (wr && in_y)
			yw[idx] <= wdata;
	end

	// ------------------------------------------------------------
	// Active coefficients, loaded by the transfer bit
	// ------------------------------------------------------------
	// Apply on transfer
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			xa <= {BANK_BYTES{RST_BYTE}};
			ya <= {BANK_BYTES{RST_BYTE}};
		end
		else if (xfer)
		begin
			xa <= xw;
			ya <= yw;
		end
	end

	// Pending flag: a write in the transfer cycle stays pending
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			pend <= 1'b0;
		else if (coef_wr)
			pend <= 1'b1;
		else if (xfer)
			pend <= 1'b0;
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = 8'h00;
		if (in_x)
			next_rdata = xw[idx];
		else if (in_y)
			next_rdata = yw[idx];
		else if (addr == ADDR_MODE)
			next_rdata = {5'h00, mode_r};
		else if (addr == ADDR_GAIN)
			next_rdata = {1'b0, gain_y, 1'b0, gain_x};
		else if (addr == ADDR_XFER)
			next_rdata[PEND_BIT] = pend;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rdata <= 8'h00;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// Filter banks
	// ------------------------------------------------------------
	pfe_fir_bank #(.TAPS(NTAP)) u_fxi
	(
		.clk(clk),
		.reset_n(reset_n),
		.din(din.i),
		.coef(xa[NTAP-1:0]),
		.acc(fxi),
		.tail(tail_xi)
	);

	pfe_fir_bank #(.TAPS(NTAP)) u_fxq
	(
		.clk(clk),
		.reset_n(reset_n),
		.din(din.q),
		.coef(xa[QOFF+:NTAP]),
		.acc(fxq),
		.tail(tail_xq)
	);

	pfe_fir_bank #(.TAPS(NTAP)) u_fyi
	(
		.clk(clk),
		.reset_n(reset_n),
		.din(yi_in),
		.coef(ya[NTAP-1:0]),
		.acc(fyi),
		.tail()
	);

	pfe_fir_bank #(.TAPS(NTAP)) u_fyq
	(
		.clk(clk),
		.reset_n(reset_n),
		.din(yq_in),
		.coef(ya[QOFF+:NTAP]),
		.acc(fyq),
		.tail()
	);

	pfe_gain_shift u_gxi (.code(gain_x), .din(fxi), .dout(gxi));
	pfe_gain_shift u_gxq (.code(gain_x), .din(fxq), .dout(gxq));
	pfe_gain_shift u_gyi (.code(gain_y), .din(fyi), .dout(gyi));
	pfe_gain_shift u_gyq (.code(gain_y), .din(fyq), .dout(gyq));

	// ------------------------------------------------------------
	// Y bank input routing
	// ------------------------------------------------------------
	always_comb
	begin
		case (mode_r)
			// Y extends the X delay line
			PFE_M_JOINED, PFE_M_HALF, PFE_M_REAL:
			begin
				yi_in = tail_xi;
				yq_in = tail_xq;
			end
			PFE_M_CASCADE:
			begin
				yi_in = sat_out(gxi);
				yq_in = sat_out(gxq);
			end
			default:
			begin
				yi_in = din.i;
				yq_in = din.q;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Output combination
	// ------------------------------------------------------------
	// Mode selects the convolution
	always_comb
	begin
		case (mode_r)
			PFE_M_SINGLE:
			begin
				next_dout.i = sat_out(gxi);
				next_dout.q = sat_out(gxq);
			end
			PFE_M_JOINED, PFE_M_REAL:
			begin
				next_dout.i = sat_out(gxi + gyi);
				next_dout.q = sat_out(gxq + gyq);
			end
			PFE_M_CASCADE:
			begin
				next_dout.i = sat_out(gyi);
				next_dout.q = sat_out(gyq);
			end
			PFE_M_COMPLEX:
			begin
				next_dout.i = sat_out(gxi + gyq);
				next_dout.q = sat_out(gxq + gyi);
			end
			PFE_M_HALF:
			begin
				next_dout.i = din.i;
				next_dout.q = sat_out(gxq + gyq + gxi + gyi);
			end
			default:
				next_dout = din;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			dout <= '0;
		else
			dout <= next_dout;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_BYPASS |=> dout == $past(din))
		else $error("bypass did not pass the input sample");

	AST_SINGLE: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_SINGLE |=> dout.i == sat_out($past(gxi)) && dout.q == sat_out($past(gxq)))
		else $error("single mode output is not the X bank alone");

	AST_JOINED: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_JOINED |-> yi_in == tail_xi ##1 dout.i == sat_out($past(gxi + gyi)))
		else $error("joined mode does not extend the X delay line");

	AST_CASCADE: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_CASCADE |-> yq_in == sat_out(gxq) ##1 dout.q == sat_out($past(gyq)))
		else $error("cascade does not route X into Y");

	AST_COMPLEX: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_COMPLEX |=> dout.i == sat_out($past(gxi) + $past(gyq))
		&& dout.q == sat_out($past(gxq) + $past(gyi)))
		else $error("complex mode cross terms wrong");

	AST_HALF: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_HALF |=> dout.i == $past(din.i))
		else $error("half complex mode filtered the I path");

	AST_REAL: assert property (@(posedge clk) disable iff (!reset_n)
		mode_r == PFE_M_REAL |-> yi_in == tail_xi ##1 dout.q == sat_out($past(gxq + gyq)))
		else $error("real mode is not the joined filter");

	AST_XREAD: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && in_x) ##1 (rd && addr == $past(addr)) |=> rdata == $past(wdata, 2))
		else $error("X coefficient readback mismatch");

	AST_YREAD: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && in_y) ##1 (rd && addr == $past(addr)) |=> rdata == $past(wdata, 2))
		else $error("Y coefficient readback mismatch");

	AST_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		coef_wr |=> $stable(xa) && $stable(ya) && pend)
		else $error("coefficient write took effect without transfer");

	AST_XFER: assert property (@(posedge clk) disable iff (!reset_n)
		xfer && !coef_wr |=> xa == $past(xw) && ya == $past(yw) && !pend)
		else $error("transfer did not load the active coefficients");

endmodule

// File: design/pfe_fir_bank.sv
// One FIR coefficient set with its delay line
`timescale 1ns/1ps
module pfe_fir_bank
	import pfe_pkg::*;
#(
	parameter int TAPS = NTAP
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Sample and coefficients
	input wire logic signed [SW-1:0] din,
	input wire logic [TAPS-1:0][CW-1:0] coef,
	// Filtered sum and oldest sample
	output logic signed [AW-1:0] acc,
	output logic signed [SW-1:0] tail
);

	logic signed [SW-1:0] line [TAPS];
	logic signed [AW-1:0] next_acc;

	if (TAPS < 1 || TAPS > QOFF)
	begin : g_chk
		$error("pfe_fir_bank: TAPS out of range");
	end

	// ------------------------------------------------------------
	// Delay line
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		for (int k = 0; k < TAPS; k++)
		begin
			if (!reset_n)
				line[k] <= '0;
			else if (k == 0)
				line[k] <= din;
			else
				line[k] <= line[k-1];
		end
	end

	// ------------------------------------------------------------
	// Convolution sum
	// ------------------------------------------------------------
	always_comb
	begin
		next_acc = '0;
		for (int k = 0; k < TAPS; k++)
			next_acc = next_acc + AW'($signed(coef[k])) * AW'(line[k]);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			acc <= '0;
		else
			acc <= next_acc;
	end

	assign tail = line[TAPS-1];

endmodule

// File: design/pfe_gain_shift.sv
// Bank gain in 6 dB steps
`timescale 1ns/1ps
module pfe_gain_shift
	import pfe_pkg::*;
(
	// Gain code
	input wire logic [2:0] code,
	// Bank sum in and scaled out
	input wire logic signed [AW-1:0] din,
	output logic signed [AW-1:0] dout
);

	always_comb
	begin
		case (code)
			G_M12: dout = din >>> 2;
			G_M6: dout = din >>> 1;
			G_P6: dout = din <<< 1;
			G_P12: dout = din <<< 2;
			default: dout = din;
		endcase
	end

endmodule

// File: design/pfe_pkg.sv
// Constants and types shared by the programmable FIR equalizer
// Contract
// - A 3-bit mode field selects how the banks convolve samples; mode 000 passes samples through.
// - Mode 001 filters I with the X bank I set and Q with the X bank Q set only.
// - Mode 010 joins X and Y into one longer filter per path, I and Q each with its own set.
// - Mode 100 cascades the X bank into the Y bank on each of the I and Q paths.
// - Mode 101 makes I out = I*X_I + Q*Y_Q and Q out = Q*X_Q + I*Y_I.
// - Mode 110 passes I unfiltered and makes Q out = Q*XY_Q + I*XY_I.
// - Mode 111 is a real 96-tap filter, each path convolved with its joined X and Y set.
// - The X bank holds 128 writable bytes at 0x0E00 to 0x0E7F, all resetting to zero.
// - The Y bank holds 128 writable bytes at 0x0F00 to 0x0F7F, reset to zero, split in I and Q.
// - New coefficients act only once bit 0 of the transfer register 0x000F is written high.
package pfe_pkg;

	// ------------------------------------------------------------
	// Datapath sizes
	// ------------------------------------------------------------
	localparam int SW = 16;
	localparam int CW = 8;
	localparam int NTAP = 48;
	localparam int AW = SW + CW + 12;
	localparam int FRAC = 7;
	localparam int BANK_BYTES = 128;
	localparam int QOFF = 64;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_XFER = 16'h000F;
	localparam logic [15:0] ADDR_MODE = 16'h0DF8;
	localparam logic [15:0] ADDR_GAIN = 16'h0DF9;
	localparam logic [15:0] ADDR_XBASE = 16'h0E00;
	localparam logic [15:0] ADDR_YBASE = 16'h0F00;
	localparam int XFER_BIT = 0;
	localparam int PEND_BIT = 1;
	localparam int GX_LSB = 0;
	localparam int GY_LSB = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [2:0] RST_GAIN = 3'h0;

	// ------------------------------------------------------------
	// Gain codes, 6 dB per step
	// ------------------------------------------------------------
	localparam logic [2:0] G_M12 = 3'h6;
	localparam logic [2:0] G_M6 = 3'h7;
	localparam logic [2:0] G_0 = 3'h0;
	localparam logic [2:0] G_P6 = 3'h1;
	localparam logic [2:0] G_P12 = 3'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		PFE_M_BYPASS = 3'h0,
		PFE_M_SINGLE = 3'h1,
		PFE_M_JOINED = 3'h2,
		PFE_M_CASCADE = 3'h4,
		PFE_M_COMPLEX = 3'h5,
		PFE_M_HALF = 3'h6,
		PFE_M_REAL = 3'h7
	} pfe_mode_t;

	typedef struct packed
	{
		logic signed [SW-1:0] i;
		logic signed [SW-1:0] q;
	} pfe_iq_t;

	typedef logic [BANK_BYTES-1:0][CW-1:0] pfe_bank_t;

endpackage

// File: verification/pfe_stream_partner.sv
// Stand-in for the converter core that feeds the equalizer
`timescale 1ns/1ps
module pfe_stream_partner
	import pfe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Impulse request from the bench
	input wire logic fire,
	input wire pfe_iq_t amp,
	// Sample stream into the equalizer
	output pfe_iq_t din
);
	// One sample per clock, zero between impulses so responses stand alone
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			din <= '0;
		else if (fire)
			din <= amp;
		else
			din <= '0;
	end
endmodule

// File: verification/test_pfe_equalizer_filter.sv
// Self-checking bench for the programmable FIR equalizer
`timescale 1ns/1ps
`define CHK(g, x) check(g, x)
module test_pfe_equalizer_filter;
	import pfe_pkg::*;
	localparam logic signed [15:0] A = 16'sh0100;
	localparam logic signed [15:0] B = 16'sh0200;
	localparam pfe_iq_t AB = '{i: A, q: B};
	localparam logic [2:0] MSET [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	localparam logic signed [23:0] EXP_I [5] = '{-A - (A >>> 1), A >>> 1,
		-A - (B >>> 1), A, -A - (A >>> 1)};
	localparam logic signed [23:0] EXP_Q [5] = '{-B - (B >>> 1), B >>> 1,
		-B - (A >>> 1), -B - (B >>> 1) - A - (A >>> 1), -B - (B >>> 1)};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic fire = 1'b0;
	pfe_iq_t amp = '0;
	pfe_iq_t din;
	pfe_iq_t dout;
	logic signed [15:0] cap_i [64];
	logic signed [15:0] cap_q [64];
	logic signed [23:0] sum_i;
	logic signed [23:0] sum_q;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	pfe_stream_partner u_src (.clk(clk), .reset_n(reset_n), .fire(fire), .amp(amp), .din(din));
	pfe_equalizer_filter u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .din(din), .dout(dout));

	// ------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, x);
	endtask

	// Write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, d);
	endtask

	// Send one impulse and record 64 output samples with their sums
	task automatic pulse(input pfe_iq_t a);
		@(posedge clk);
		amp <= a;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		sum_i = '0;
		sum_q = '0;
		for (int k = 0; k < 64; k++)
		begin
			@(posedge clk);
			#1;
			cap_i[k] = dout.i;
			cap_q[k] = dout.q;
			sum_i = sum_i + cap_i[k];
			sum_q = sum_q + cap_q[k];
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd_chk(ADDR_XBASE, RST_BYTE);
		rd_chk(ADDR_XBASE + 16'h007F, RST_BYTE);
		rd_chk(ADDR_YBASE + 16'h007F, RST_BYTE);
		rd_chk(ADDR_MODE, 8'h00);
		rd_chk(ADDR_GAIN, 8'h00);
		rd_chk(ADDR_XFER, 8'h00);
		wr_reg(ADDR_XBASE + 16'h007F, 8'h5A);
		wr_reg(ADDR_YBASE + 16'h007F, 8'hA5);
		wr_reg(16'h0E80, 8'h33);
		rd_chk(ADDR_XBASE + 16'h007F, 8'h5A);
		rd_chk(ADDR_YBASE + 16'h007F, 8'hA5);
		rd_chk(16'h0E80, 8'h00);
		wr_rd(ADDR_XBASE + 16'h0030, 8'h3C);
		wr_rd(ADDR_YBASE + 16'h0070, 8'hC3);
		wr_reg(ADDR_MODE, 8'hFF);
		rd_chk(ADDR_MODE, 8'h07);
		wr_reg(ADDR_GAIN, 8'hFF);
		rd_chk(ADDR_GAIN, 8'h77);
		wr_reg(ADDR_MODE, 8'h00);
		wr_reg(ADDR_GAIN, 8'h00);
	endtask

	task automatic t_bypass;
		pulse(AB);
		`CHK(cap_i[0], A);
		`CHK(cap_q[0], B);
		`CHK(sum_i, A);
		wr_reg(ADDR_MODE, 8'h03);
		pulse(AB);
		`CHK(cap_q[0], B);
		`CHK(sum_q, B);
	endtask

	// Coefficients stay idle until the transfer bit is written
	task automatic t_xfer;
		wr_reg(ADDR_XBASE, 8'h80);
		wr_reg(ADDR_XBASE + 16'h0040, 8'h80);
		wr_reg(ADDR_YBASE, 8'hC0);
		wr_reg(ADDR_YBASE + 16'h0040, 8'hC0);
		wr_reg(ADDR_MODE, 8'h01);
		pulse(AB);
		`CHK(sum_i, 24'h000000);
		`CHK(sum_q, 24'h000000);
		rd_chk(ADDR_XFER, 8'h02);
		wr_reg(ADDR_XFER, 8'h01);
		rd_chk(ADDR_XFER, 8'h00);
		pulse(AB);
		`CHK(cap_i[2], -A);
		`CHK(cap_q[2], -B);
		`CHK(sum_i, -A);
		`CHK(sum_q, -B);
	endtask

	task automatic t_modes;
		for (int m = 0; m < 5; m++)
		begin
			wr_reg(ADDR_MODE, {5'h00, MSET[m]});
			pulse(AB);
			`CHK(sum_i, EXP_I[m]);
			`CHK(sum_q, EXP_Q[m]);
		end
		`CHK(cap_i[2], -A);
		`CHK(cap_i[50], -(A >>> 1));
	endtask

	task automatic t_gain;
		wr_reg(ADDR_MODE, 8'h01);
		wr_reg(ADDR_GAIN, {1'b0, G_0, 1'b0, G_P6});
		pulse(AB);
		`CHK(cap_i[2], -(A <<< 1));
		wr_reg(ADDR_GAIN, {1'b0, G_0, 1'b0, G_M12});
		pulse(AB);
		`CHK(cap_q[2], -(B >>> 2));
		wr_reg(ADDR_GAIN, {1'b0, G_0, 1'b0, G_P12});
		pulse(AB);
		`CHK(cap_q[2], -(B <<< 2));
		wr_reg(ADDR_MODE, 8'h02);
		wr_reg(ADDR_GAIN, {1'b0, G_M6, 1'b0, G_0});
		pulse(AB);
		`CHK(sum_i, -A - (A >>> 2));
	endtask

	// ------------------------------------------------------------
	// Sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			$display("mismatch at %0t: run did not finish", $time);
			report_and_stop();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_bypass();
		t_xfer();
		t_modes();
		t_gain();
		report_and_stop();
	end
endmodule
